// ### rtl/resync_pkg.sv
package resync_pkg;

	// ----------------------------------------------------------------
	// serial word layout
	// ----------------------------------------------------------------
	localparam int          WORD_W        = 29;
	localparam int          SEL_W         = 3;
	localparam int          NUM_REGS      = 5;
	localparam logic [2:0]  SEL_INT_FRAC  = 3'h0;   // integer_fraction_register
	localparam logic [2:0]  SEL_PHASE     = 3'h1;   // phase_word_register
	localparam logic [2:0]  SEL_DENOM     = 3'h2;   // denominator_register
	localparam logic [2:0]  SEL_FUNC      = 3'h3;   // function_settings_register
	localparam logic [2:0]  SEL_DIV_TIMER = 3'h4;   // divider_timer_register
	localparam logic [28:0] REG_RESET     = 29'h0000000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          FIELD_W       = 12;
	localparam int          MOD_RST_BIT   = 14;     // function settings, modulator reset control
	localparam int          MODE_LSB      = 19;     // divider/timer, two-bit divider mode
	localparam int          COUNT_LSB     = 7;      // divider/timer, sync interval count
	localparam int          DENOM_LSB     = 3;      // denominator register
	localparam int          PHASE_LSB     = 3;      // phase word register
	localparam logic [1:0]  MODE_FAST     = 2'h1;
	localparam logic [1:0]  MODE_RESYNC   = 2'h2;

	// ----------------------------------------------------------------
	// timing figures
	// ----------------------------------------------------------------
	localparam int          MCLK_MHZ      = 25;
	localparam int          SER_CLK_MAX_MHZ = 20;   // host limit; mclk only resolves far slower

	// realignment sequencer, one-hot
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h1,
		ST_FIRST  = 3'h2,
		ST_SECOND = 3'h4
	} realign_e;

	// true when a 0-based count has reached the last step of a span of lim
	function automatic logic last_step(input logic [11:0] cnt, input logic [11:0] lim);
		last_step = ({1'b0, cnt} + 13'h0001) >= {1'b0, lim};
	endfunction

endpackage

// ### rtl/timer_if.sv
interface timer_if;
	logic        tick;        // one comparison clock rising edge
	logic        restart;     // one cycle after a load strobe rise, new words in place
	logic [1:0]  mode;
	logic [11:0] count;
	logic [11:0] denom;
	logic        sync_pulse;
	logic        realign;
	logic        fast_active;

	modport timer (input tick, restart, mode, count, denom, output sync_pulse, realign, fast_active);
	modport ctrl  (output tick, restart, mode, count, denom, input sync_pulse, realign, fast_active);
endinterface

// ### rtl/sync_timer.sv
module sync_timer
	import resync_pkg::*;
(
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// control side
	timer_if.timer    tif
);

	realign_e    state,    next_state;
	logic [11:0] den_cnt,  next_den_cnt;
	logic [11:0] div_cnt,  next_div_cnt;
	logic [11:0] fast_cnt, next_fast_cnt;
	logic        sync_q,   next_sync;
	logic        realign_q, next_realign;
	logic        fast_q,   next_fast;
	logic        resync_en;

	assign resync_en = tif.mode == MODE_RESYNC;

	// ----------------------------------------------------------------
	// sync interval and fast-lock timers
	// ----------------------------------------------------------------
	// the interval is count spans of denom comparison ticks
	always_comb begin
		next_state    = state;
		next_den_cnt  = den_cnt;
		next_div_cnt  = div_cnt;
		next_fast_cnt = fast_cnt;
		next_sync     = 1'b0;
		next_realign  = 1'b0;
		if (tif.restart) begin
			next_den_cnt  = 12'h000;
			next_div_cnt  = 12'h000;
			next_state    = resync_en ? ST_FIRST : ST_IDLE;
			next_fast_cnt = (tif.mode == MODE_FAST) ? tif.count : 12'h000;
		end else if (tif.tick) begin
			if (fast_cnt != 12'h000)
				next_fast_cnt = fast_cnt - 12'h001;
			if (resync_en) begin
				if (last_step(den_cnt, tif.denom)) begin
					next_den_cnt = 12'h000;
					if (last_step(div_cnt, tif.count)) begin
						next_div_cnt = 12'h000;
						next_sync    = 1'b1;
						case (state)
							ST_FIRST:  next_state = ST_SECOND;
							ST_SECOND: begin
								next_state   = ST_IDLE;
								next_realign = 1'b1;
							end
							default:   next_state = ST_IDLE;
						endcase
					end else begin
						next_div_cnt = div_cnt + 12'h001;
					end
				end else begin
					next_den_cnt = den_cnt + 12'h001;
				end
			end else begin
				next_den_cnt = 12'h000;
				next_div_cnt = 12'h000;
				next_state   = ST_IDLE;
			end
		end
		next_fast = next_fast_cnt != 12'h000;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			den_cnt   <= 12'h000;
			div_cnt   <= 12'h000;
			fast_cnt  <= 12'h000;
			sync_q    <= 1'b0;
			realign_q <= 1'b0;
			fast_q    <= 1'b0;
		end else begin
			state     <= next_state;
			den_cnt   <= next_den_cnt;
			div_cnt   <= next_div_cnt;
			fast_cnt  <= next_fast_cnt;
			sync_q    <= next_sync;
			realign_q <= next_realign;
			fast_q    <= next_fast;
		end
	end

	assign tif.sync_pulse  = sync_q;
	assign tif.realign     = realign_q;
	assign tif.fast_active = fast_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// helper: ticks since the last sync or restart
	logic [23:0] gap;
	logic        seen_sync;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gap       <= 24'h000000;
			seen_sync <= 1'b0;
		end else if (tif.restart || !resync_en) begin
			gap       <= 24'h000000;
			seen_sync <= 1'b0;
		end else begin
			if (sync_q) begin
				gap       <= {23'h000000, tif.tick};
				seen_sync <= 1'b1;
			end else if (tif.tick) begin
				gap <= gap + 24'h000001;
			end
		end
	end

	sync_spacing_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sync_q && seen_sync && $stable(tif.count) && $stable(tif.denom) && tif.denom >= 12'h002
		|-> gap == 24'(tif.count) * 24'(tif.denom))
		else $error("sync pulses not spaced by count times denominator ticks");

	realign_sync_a: assert property (@(posedge mclk) disable iff (!rst_n)
		realign_q |-> sync_q && $past(state) == ST_SECOND)
		else $error("realign not on the second sync pulse");

	fast_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tif.restart && tif.mode == MODE_FAST && tif.count != 12'h000 |=> fast_q ##0 !sync_q)
		else $error("fast-lock timer did not start on load");

	restart_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tif.restart |=> !sync_q && den_cnt == 12'h000 && div_cnt == 12'h000)
		else $error("load did not restart the sync timer");

	no_resync_a: assert property (@(posedge mclk) disable iff (!rst_n)
		tif.mode != MODE_RESYNC && $past(tif.mode) != MODE_RESYNC |-> !sync_q && !realign_q)
		else $error("sync pulse outside resync mode");

endmodule // sync_timer

// ### rtl/phase_resync_top.sv
// Contract
// - modulator reset bit 0: restart modulator from phase word on integer/fraction write
// - divider mode binary 10 enables phase resynchronization
// - resync timer pulses every count times denominator comparison periods
// - sync interval count is twelve bits at 18:7, host keeps it 1 to 4095
// - sync timer uses denominator from bits 14:3 of denominator register
// - output phase realigns on second sync pulse after load strobe rise
// - phase word moves output phase in steps of one denominator-th turn
// - shift one data bit in on every serial clock rising edge
// - load strobe high commits the 29 shifted bits to the selected register
// - divider mode binary 01 runs the fast-lock timer from the same count
// - denominator is 2 to 4095, host programs it so
module phase_resync_top
	import resync_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// three-wire serial port, asynchronous to mclk
	input  wire logic        ser_clk,
	input  wire logic        ser_data,
	input  wire logic        load_strobe,
	// comparison clock, sampled as a plain input
	input  wire logic        cmp_clk,
	// programmed words
	output logic [28:0]      int_frac_word,
	output logic [11:0]      fraction_denominator,
	output logic [11:0]      phase_start,
	// modulator and resync events
	output logic             modulator_restart,
	output logic             resync_enabled,
	output logic             sync_pulse,
	output logic             phase_realign,
	output logic             fast_lock_active
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// bit 0 ser_clk, 1 ser_data, 2 load_strobe, 3 cmp_clk
	// every stage resets low, the idle level of each pin, so reset makes no false edge;
	// only sync_in reads meta, all edge logic works from the second stage onward
	logic [3:0] meta, sync_in, sync_d;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta    <= 4'h0;
			sync_in <= 4'h0;
			sync_d  <= 4'h0;
		end else begin
			meta    <= {cmp_clk, load_strobe, ser_data, ser_clk};
			sync_in <= meta;
			sync_d  <= sync_in;
		end
	end

	logic sclk_rise, le_rise, cmp_rise, data_s;
	assign sclk_rise = sync_in[0] & ~sync_d[0];
	assign data_s    = sync_in[1];
	assign le_rise   = sync_in[2] & ~sync_d[2];
	assign cmp_rise  = sync_in[3] & ~sync_d[3];

	// ----------------------------------------------------------------
	// input shift register and destination registers
	// ----------------------------------------------------------------
	// mclk must run several times the serial clock; a 20 MHz serial clock
	// is beyond what a 25 MHz sampler can resolve
	logic [WORD_W-1:0] shift_reg, next_shift;
	logic [WORD_W-1:0] regs [NUM_REGS];
	logic [WORD_W-1:0] next_regs [NUM_REGS];
	logic [2:0]        sel;
	logic              next_restart;
	logic [11:0]       ph_word, den_word, next_phase_start;

	assign sel      = shift_reg[SEL_W-1:0];
	assign ph_word  = regs[SEL_PHASE][PHASE_LSB +: FIELD_W];
	assign den_word = regs[SEL_DENOM][DENOM_LSB +: FIELD_W];

	always_comb begin
		next_shift   = shift_reg;
		next_regs    = regs;
		next_restart = 1'b0;
		if (sclk_rise)
			next_shift = {shift_reg[WORD_W-2:0], data_s};
		if (le_rise && sel < 3'(NUM_REGS)) begin
			next_regs[sel] = shift_reg;
			if (sel == SEL_INT_FRAC && !regs[SEL_FUNC][MOD_RST_BIT])
				next_restart = 1'b1;
		end
		// keep the start word inside one turn for phase words below twice the denominator, so each step is 1/denominator
		if (ph_word >= den_word && den_word != 12'h000)
			next_phase_start = ph_word - den_word;
		else
			next_phase_start = ph_word;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			shift_reg         <= REG_RESET;
			for (int i = 0; i < NUM_REGS; i++)
				regs[i] <= REG_RESET;
			modulator_restart <= 1'b0;
			phase_start       <= 12'h000;
		end else begin
			shift_reg         <= next_shift;
			regs              <= next_regs;
			modulator_restart <= next_restart;
			phase_start       <= next_phase_start;
		end
	end

	assign int_frac_word        = regs[SEL_INT_FRAC];
	assign fraction_denominator = den_word;

	// mode level as a flop so the output is registered
	always_ff @(posedge mclk) begin
		if (!rst_n)
			resync_enabled <= 1'b0;
		else
			resync_enabled <= regs[SEL_DIV_TIMER][MODE_LSB +: 2] == MODE_RESYNC;
	end

	// ----------------------------------------------------------------
	// timer restart alignment
	// ----------------------------------------------------------------
	// the commit and the strobe edge fall in one cycle; restarting the timer
	// a cycle later lets it read the freshly written mode, count and
	// denominator instead of the values that the load replaces
	logic timer_restart, next_timer_restart;
	always_comb begin
		next_timer_restart = le_rise;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			timer_restart <= 1'b0;
		else
			timer_restart <= next_timer_restart;
	end

	// ----------------------------------------------------------------
	// sync timer
	// ----------------------------------------------------------------
	timer_if tif ();
	assign tif.tick    = cmp_rise;
	assign tif.restart = timer_restart;
	assign tif.mode    = regs[SEL_DIV_TIMER][MODE_LSB +: 2];
	assign tif.count   = regs[SEL_DIV_TIMER][COUNT_LSB +: FIELD_W];
	assign tif.denom   = den_word;

	sync_timer u_timer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tif   (tif)
	);

	assign sync_pulse       = tif.sync_pulse;
	assign phase_realign    = tif.realign;
	assign fast_lock_active = tif.fast_active;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [WORD_W-2:0] shift_low;
	assign shift_low = shift_reg[WORD_W-2:0];

	// each serial rise moves the word up by one bit
	shift_in_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sclk_rise |=> shift_reg == {$past(shift_low), $past(data_s)})
		else $error("serial bit not shifted in");

	// no serial rise, no movement
	shift_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!sclk_rise |=> $stable(shift_reg))
		else $error("shift register moved without a serial clock rise");

	// denominator field lands on its load
	load_commit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && sel == SEL_DENOM |=> fraction_denominator == $past(shift_reg[14:3]))
		else $error("load strobe did not commit the word");

	// integer/fraction word lands whole
	word_commit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && sel == SEL_INT_FRAC |=> int_frac_word == $past(shift_reg))
		else $error("integer/fraction word not committed");

	// phase word lands from its field
	phase_commit_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && sel == SEL_PHASE |=> ph_word == $past(shift_reg[PHASE_LSB +: FIELD_W]))
		else $error("phase word not committed");

	// selectors past the last register write nothing
	unused_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && sel >= 3'(NUM_REGS) |=> $stable(int_frac_word) && $stable(den_word) && $stable(ph_word))
		else $error("unused selector changed a register");

	// integer/fraction write with the reset bit clear restarts the modulator
	restart_on_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && sel == SEL_INT_FRAC && !regs[SEL_FUNC][MOD_RST_BIT] |=> modulator_restart ##1 !modulator_restart)
		else $error("modulator restart pulse missing");

	// a restart always traces back to such a write
	restart_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
		modulator_restart |-> $past(le_rise) && $past(sel) == SEL_INT_FRAC)
		else $error("modulator restarted without an integer/fraction write");

	// other selectors, or the reset bit set, leave the modulator running
	restart_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && (sel != SEL_INT_FRAC || regs[SEL_FUNC][MOD_RST_BIT]) |=> !modulator_restart)
		else $error("modulator restarted although the write did not ask for it");

	// the restart is a single-cycle pulse
	restart_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
		modulator_restart |=> !modulator_restart)
		else $error("modulator restart longer than one cycle");

	// the timer restarts with the freshly written mode and count
	timer_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
		le_rise && sel == SEL_DIV_TIMER |=> tif.restart && tif.mode == $past(shift_reg[MODE_LSB +: 2])
			&& tif.count == $past(shift_reg[COUNT_LSB +: FIELD_W]))
		else $error("timer restart did not see the new divider word");

	// start word stays inside one turn unless the phase word spans two
	phase_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$stable(den_word) && den_word >= 12'h002 ##1 $stable(den_word)
			|-> phase_start < den_word || {1'b0, $past(ph_word)} >= {den_word, 1'b0})
		else $error("phase start outside one turn");

endmodule // phase_resync_top

// ### bench/host_model.sv
module host_model (
	// mclk in, serial lines towards the device
	input  wire logic mclk,
	output logic      ser_clk,
	output logic      ser_data,
	output logic      load_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// three-wire writer
	// ----------------------------------------------------------------
	localparam int HALF = 4;	// mclk cycles per serial half period, 320 ns period

	// clock stands low between frames
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		load_strobe = 1'b0;
	end

	// drive off the sampling edge so the device sees settled levels
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// msb first, selector bits last; data settles a half period before each rise
	task automatic send_word(input logic [28:0] w);
		for (int i = 28; i >= 0; i--) begin
			ser_data = w[i];
			wait_cyc(HALF);
			ser_clk = 1'b1;
			wait_cyc(HALF);
			ser_clk = 1'b0;
		end
		ser_data = ~w[0];	// released line must not keep showing the last bit
		wait_cyc(HALF);
		load_strobe = 1'b1;
		wait_cyc(HALF);
		load_strobe = 1'b0;
	endtask
endmodule // host_model

// ### bench/test_phase_resync_top.sv
module test_phase_resync_top
	import resync_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// clocks, pins and counters
	// ----------------------------------------------------------------
	logic        mclk;
	logic        rst_n;
	logic        cmp_clk;
	logic        ser_clk;
	logic        ser_data;
	logic        load_strobe;
	logic [28:0] int_frac_word;
	logic [11:0] fraction_denominator;
	logic [11:0] phase_start;
	logic        modulator_restart;
	logic        resync_enabled;
	logic        sync_pulse;
	logic        phase_realign;
	logic        fast_lock_active;
	int          err_count = 0;
	int          checks_done = 0;
	int          tick_cnt = 0;
	int          mr_cnt = 0;

	phase_resync_top u_dut (.mclk(mclk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
		.load_strobe(load_strobe), .cmp_clk(cmp_clk), .int_frac_word(int_frac_word),
		.fraction_denominator(fraction_denominator), .phase_start(phase_start),
		.modulator_restart(modulator_restart), .resync_enabled(resync_enabled), .sync_pulse(sync_pulse),
		.phase_realign(phase_realign), .fast_lock_active(fast_lock_active));
	host_model u_host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));

	// 25 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// comparison clock, 200 ns, edges kept away from mclk edges
	initial begin
		cmp_clk = 1'b0;
		#7;
		forever #100 cmp_clk = ~cmp_clk;
	end

	// bench-side tick and restart pulse counts
	always @(posedge cmp_clk) tick_cnt <= tick_cnt + 1;
	always @(posedge mclk) if (modulator_restart === 1'b1) mr_cnt <= mr_cnt + 1;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// a write plus margin for the pin synchronisers
	task automatic send(input logic [28:0] w);
		u_host.send_word(w);
		u_host.wait_cyc(4);
	endtask

	// bounded wait for the next sync pulse; returns tick count and realign flag
	task automatic wait_sync(output int t, output logic rl);
		int n;
		n = 0;
		@(negedge mclk);
		while (sync_pulse !== 1'b1 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3000) begin
			err_count++;
			end_sim();
		end
		t = tick_cnt;
		rl = phase_realign;
	endtask

	function automatic logic [28:0] w_fld(input logic [2:0] sel, input logic [11:0] f);
		return {14'h0000, f, sel};
	endfunction

	function automatic logic [28:0] w_div(input logic [1:0] m, input logic [11:0] c);
		return {8'h00, m, c, 4'h0, SEL_DIV_TIMER};
	endfunction

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [11:0] d;
		logic [11:0] c;
		logic [11:0] p;
		logic [11:0] pv [5];
		logic [28:0] w;
		logic        rl;
		int          t0;
		int          t1;
		int          m0;
		rst_n = 1'b0;
		void'($urandom(28));
		repeat (5) @(posedge mclk);
		#1 rst_n = 1'b1;
		u_host.wait_cyc(1);
		check(int_frac_word, 32'h0);
		check({fraction_denominator, phase_start, modulator_restart, resync_enabled, sync_pulse,
			phase_realign, fast_lock_active}, 32'h0);
		// restart pulse only while the function bit is clear
		for (int b = 0; b < 2; b++) begin
			send({14'h0000, b[0], 11'h000, SEL_FUNC});
			w = {26'($urandom()), SEL_INT_FRAC};
			m0 = mr_cnt;
			send(w);
			check(32'(mr_cnt - m0), 32'(1 - b));
			check(int_frac_word, w);
		end
		// phase word reduced below the denominator, boundaries included; last value rewritten
		d = 12'(2 + $urandom_range(4000));
		send(w_fld(SEL_DENOM, d));
		check(fraction_denominator, d);
		pv = '{12'h000, d - 12'h001, d, 12'($urandom_range(d - 1)), 12'h000};
		foreach (pv[i]) begin
			send(w_fld(SEL_PHASE, pv[i]));
			p = (pv[i] >= d) ? pv[i] - d : pv[i];
			check(phase_start, p);
		end
		// unused selector leaves the denominator, phase and integer/fraction registers alone
		send(w_fld(3'h5, ~d));
		check(fraction_denominator, d);
		check(phase_start, 12'h000);
		check(int_frac_word, w);
		// resync spacing and realignment on the second pulse
		for (int k = 0; k < 4; k++) begin
			d = 12'(2 + $urandom_range(5));
			c = 12'(1 + $urandom_range(2));
			if (k == 0) begin
				d = 12'h002;
				c = 12'h001;
			end
			send(w_div(2'h0, c));
			send(w_fld(SEL_DENOM, d));
			send(w_div(MODE_RESYNC, c));
			check(resync_enabled, 1'b1);
			wait_sync(t0, rl);
			check(rl, 1'b0);
			wait_sync(t1, rl);
			check(rl, 1'b1);
			check(32'(t1 - t0), 32'(c * d));
			wait_sync(t0, rl);
			check(rl, 1'b0);
			check(32'(t0 - t1), 32'(c * d));
		end
		// fast-lock timer from the same count field
		c = 12'(4 + $urandom_range(4));
		send(w_div(MODE_FAST, c));
		t0 = tick_cnt;
		check(resync_enabled, 1'b0);
		check(fast_lock_active, 1'b1);
		m0 = 0;
		while (fast_lock_active === 1'b1 && m0 < 500) begin
			u_host.wait_cyc(1);
			m0++;
		end
		t1 = tick_cnt;
		check(32'((t1 - t0) <= c && (t1 - t0) + 3 >= c), 32'h1);
		end_sim();
	end
endmodule // test_phase_resync_top
